//--- logic/pbs_defines.svh
// timing constants and build options for the pushbutton power sequencer
`ifndef PBS_DEFINES_SVH
`define PBS_DEFINES_SVH
// =====================================================================
// clock and tick
`define PBS_CLK_HZ 125000000
`define PBS_TICK_MS 1
`define PBS_TICK_CYC ((`PBS_CLK_HZ / 1000) * `PBS_TICK_MS)
// kill filter, least time rounds up
`define PBS_KILL_PW_NS 30000
`define PBS_KILL_PW_CYC ((`PBS_KILL_PW_NS + 7) / 8)
// millisecond figures and the forced-off cycle count
`define PBS_ON_DEB_MS 32
`define PBS_BLANK_MS 512
`define PBS_OFF_DEB_MS 32
`define PBS_INT_MS 32
`define PBS_PD_MIN_MS 64
`define PBS_LOCK_MS 256
`define PBS_PD_CYCLES 16
`endif

//--- logic/pbs_pkg.sv
// types for the pushbutton power sequencer
package pbs_pkg;
  typedef enum logic [3:0] {
    PBS_IDLE, PBS_ON_DEB, PBS_BLANK, PBS_REL_DEB, PBS_NORMAL,
    PBS_INT_HOLD, PBS_PD_TIMER, PBS_LOCKOUT
  } pbs_state_t;
  typedef struct packed {
    pbs_state_t st;
    logic [1:0] pb_sync;
    logic [1:0] kill_sync;
    logic pb_prev;
    logic [16:0] tick_cnt;
    logic tick;
    logic [15:0] ms_cnt;
    logic [4:0] pd_cyc;
    logic [12:0] kill_cnt;
    logic kill_low;
    logic en_act;
    logic supply_en;
    logic pd_req_n;
  } pbs_regs_t;
endpackage : pbs_pkg

//--- logic/pbs_sequencer.sv
// pushbutton power sequencer: debounce, enable, blanking, interrupt, forced off, lockout
`include "pbs_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module pbs_sequencer
  import pbs_pkg::*;
#(
  parameter logic EN_ACTIVE_HIGH = 1'b1,          // polarity option
  parameter logic [15:0] TURN_ON_EXTRA_DELAY = 16'h0000,   // ms
  parameter logic [15:0] FORCED_OFF_EXTRA_DELAY = 16'h0000, // ms, spread over 16 cycles
  parameter int TICK_CYC = `PBS_TICK_CYC,
  parameter int KILL_PW_CYC = `PBS_KILL_PW_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // pins
  input wire logic button_in_n_i,
  input wire logic kill_n_i,
  // outputs
  output logic supply_en_o,
  output logic pd_req_n_o
);

  // =====================================================================
  // derived timer lengths
  localparam logic [15:0] ON_MS = 16'(`PBS_ON_DEB_MS) + TURN_ON_EXTRA_DELAY;
  localparam logic [15:0] PD_CYC_MS = 16'((`PBS_PD_MIN_MS - `PBS_OFF_DEB_MS - `PBS_INT_MS) / `PBS_PD_CYCLES)
                                      + 16'(FORCED_OFF_EXTRA_DELAY / 16'(`PBS_PD_CYCLES));
  localparam logic [16:0] TICK_LAST = 17'(TICK_CYC - 1);
  localparam logic [12:0] KILL_LAST = 13'(KILL_PW_CYC - 1);

  pbs_regs_t r_ff;
  pbs_regs_t nxt_r;
  logic pb_low;
  logic kill_low_raw;

  assign pb_low = ~r_ff.pb_sync[1];
  assign kill_low_raw = ~r_ff.kill_sync[1];

  // =====================================================================
  // next-state logic
  always_comb begin
    nxt_r = r_ff;
    nxt_r.pb_sync = {r_ff.pb_sync[0], button_in_n_i};
    nxt_r.kill_sync = {r_ff.kill_sync[0], kill_n_i};
    nxt_r.pb_prev = r_ff.pb_sync[1];
    // millisecond prescaler
    nxt_r.tick = 1'b0;
    if (r_ff.tick_cnt == TICK_LAST) begin
      nxt_r.tick_cnt = 17'h00000;
      nxt_r.tick = 1'b1;
    end else begin
      nxt_r.tick_cnt = r_ff.tick_cnt + 17'h00001;
    end
    // shutdown low filter
    if (!kill_low_raw) begin
      nxt_r.kill_cnt = 13'h0000;
      nxt_r.kill_low = 1'b0;
    end else if (r_ff.kill_cnt == KILL_LAST) begin
      nxt_r.kill_low = 1'b1;
    end else begin
      nxt_r.kill_cnt = r_ff.kill_cnt + 13'h0001;
    end
    if (r_ff.tick) begin
      nxt_r.ms_cnt = r_ff.ms_cnt + 16'h0001;
    end
    unique case (r_ff.st)
      PBS_IDLE: begin
        nxt_r.ms_cnt = 16'h0000;
        if (r_ff.pb_prev && pb_low) begin
          nxt_r.st = PBS_ON_DEB;
        end
      end
      PBS_ON_DEB: begin
        if (!pb_low) begin
          nxt_r.st = PBS_IDLE;
        end else if (r_ff.ms_cnt >= ON_MS) begin
          nxt_r.st = PBS_BLANK;
          nxt_r.en_act = 1'b1;
          nxt_r.ms_cnt = 16'h0000;
        end
      end
      PBS_BLANK: begin
        // inputs not looked at until the window closes
        if (r_ff.ms_cnt >= 16'(`PBS_BLANK_MS)) begin
          nxt_r.ms_cnt = 16'h0000;
          if (kill_low_raw) begin
            nxt_r.en_act = 1'b0;
            nxt_r.st = PBS_IDLE;
          end else begin
            nxt_r.st = PBS_REL_DEB;
          end
        end
      end
      PBS_REL_DEB: begin
        if (r_ff.kill_low) begin
          nxt_r.en_act = 1'b0;
          nxt_r.ms_cnt = 16'h0000;
          nxt_r.st = PBS_LOCKOUT;
        end else if (pb_low) begin
          nxt_r.ms_cnt = 16'h0000;
        end else if (r_ff.ms_cnt >= 16'(`PBS_OFF_DEB_MS)) begin
          nxt_r.ms_cnt = 16'h0000;
          nxt_r.st = PBS_NORMAL;
        end
      end
      PBS_NORMAL: begin
        if (r_ff.kill_low) begin
          nxt_r.en_act = 1'b0;
          nxt_r.ms_cnt = 16'h0000;
          nxt_r.st = PBS_LOCKOUT;
        end else if (!pb_low) begin
          nxt_r.ms_cnt = 16'h0000;
        end else if (r_ff.ms_cnt >= 16'(`PBS_OFF_DEB_MS)) begin
          nxt_r.pd_req_n = 1'b0;
          nxt_r.ms_cnt = 16'h0000;
          nxt_r.st = PBS_INT_HOLD;
        end
      end
      PBS_INT_HOLD: begin
        if (r_ff.kill_low) begin
          nxt_r.en_act = 1'b0;
          nxt_r.pd_req_n = 1'b1;
          nxt_r.ms_cnt = 16'h0000;
          nxt_r.st = PBS_LOCKOUT;
        end else if (r_ff.ms_cnt >= 16'(`PBS_INT_MS)) begin
          nxt_r.ms_cnt = 16'h0000;
          nxt_r.pd_cyc = 5'h00;
          if (pb_low) begin
            nxt_r.st = PBS_PD_TIMER;
          end else begin
            nxt_r.pd_req_n = 1'b1;
            nxt_r.st = PBS_NORMAL;
          end
        end
      end
      PBS_PD_TIMER: begin
        if (r_ff.kill_low) begin
          nxt_r.en_act = 1'b0;
          nxt_r.pd_req_n = 1'b1;
          nxt_r.ms_cnt = 16'h0000;
          nxt_r.st = PBS_LOCKOUT;
        end else if (!pb_low) begin
          nxt_r.pd_req_n = 1'b1;
          nxt_r.ms_cnt = 16'h0000;
          nxt_r.st = PBS_NORMAL;
        end else if (r_ff.pd_cyc == 5'(`PBS_PD_CYCLES)) begin
          nxt_r.en_act = 1'b0;
          nxt_r.pd_req_n = 1'b1;
          nxt_r.ms_cnt = 16'h0000;
          nxt_r.st = PBS_IDLE;
        end else if (r_ff.ms_cnt >= PD_CYC_MS) begin
          nxt_r.ms_cnt = 16'h0000;
          nxt_r.pd_cyc = r_ff.pd_cyc + 5'h01;
        end
      end
      PBS_LOCKOUT: begin
        if (r_ff.ms_cnt >= 16'(`PBS_LOCK_MS)) begin
          nxt_r.st = PBS_IDLE;
        end
      end
      default: begin
        nxt_r.st = PBS_IDLE;
        nxt_r.en_act = 1'b0;
        nxt_r.pd_req_n = 1'b1;
      end
    endcase
    nxt_r.supply_en = (nxt_r.en_act == EN_ACTIVE_HIGH);
  end

  // =====================================================================
  // state register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      r_ff <= '{st: PBS_IDLE, pb_sync: 2'h3, kill_sync: 2'h3, pb_prev: 1'b1,
                tick_cnt: 17'h00000, tick: 1'b0, ms_cnt: 16'h0000, pd_cyc: 5'h00,
                kill_cnt: 13'h0000, kill_low: 1'b0, en_act: 1'b0,
                supply_en: ~EN_ACTIVE_HIGH, pd_req_n: 1'b1};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign supply_en_o = r_ff.supply_en;
  assign pd_req_n_o = r_ff.pd_req_n;

  // =====================================================================
  // assertions
  AST_RESET_OFF: assert property (@(posedge mclk_i) $fell(rst_i) |-> !r_ff.en_act)
    else $error("enable active out of reset");
  AST_ON_NEEDS_PRESS: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(r_ff.en_act) |-> $past(r_ff.st) == PBS_ON_DEB && $past(pb_low))
    else $error("enable without press");
  AST_ON_RESTART: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.st == PBS_ON_DEB && !pb_low |=> r_ff.st == PBS_IDLE)
    else $error("turn-on timer not restarted");
  AST_BLANK_HOLDS: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.st == PBS_BLANK && r_ff.ms_cnt < 16'(`PBS_BLANK_MS) |=> r_ff.en_act)
    else $error("enable dropped during blanking");
  AST_ABORT: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.st == PBS_BLANK && r_ff.ms_cnt >= 16'(`PBS_BLANK_MS) && kill_low_raw |=> !r_ff.en_act)
    else $error("abort missed");
  AST_REQ_NO_EN: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(r_ff.pd_req_n) |-> r_ff.en_act && $past(r_ff.en_act))
    else $error("request changed enable");
  AST_KILL_OFF: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.kill_low && r_ff.st inside {PBS_NORMAL, PBS_INT_HOLD} |=> !r_ff.en_act)
    else $error("kill did not release enable");
  AST_FORCED_OFF: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.st == PBS_PD_TIMER && !r_ff.kill_low && pb_low && r_ff.pd_cyc == 5'(`PBS_PD_CYCLES)
    |=> !r_ff.en_act && r_ff.pd_req_n)
    else $error("forced off missed");
  AST_POLARITY: assert property (@(posedge mclk_i) disable iff (rst_i)
    supply_en_o == (r_ff.en_act == EN_ACTIVE_HIGH))
    else $error("enable polarity wrong");
  AST_LOCKOUT: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.st == PBS_LOCKOUT |=> r_ff.st inside {PBS_LOCKOUT, PBS_IDLE})
    else $error("lockout left early");

  // =====================================================================
  // state-by-state checks
  // idle never holds the supply on
  AST_IDLE_OFF: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.st == PBS_IDLE |-> !r_ff.en_act)
    else $error("enable active in idle");
  // idle never holds the request low
  AST_IDLE_REQ_HIGH: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.st == PBS_IDLE |-> r_ff.pd_req_n)
    else $error("request low in idle");

  // turn-on debounce keeps the supply off
  AST_ON_DEB_OFF: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.st == PBS_ON_DEB |-> !r_ff.en_act)
    else $error("enable active during turn-on debounce");
  // a full continuous press turns the supply on
  AST_ON_TIME: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.st == PBS_ON_DEB && pb_low && r_ff.ms_cnt >= ON_MS |=> r_ff.st == PBS_BLANK && r_ff.en_act)
    else $error("turn-on not taken");
  // no enable before the turn-on time has run
  AST_ON_NOT_EARLY: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.st == PBS_ON_DEB && r_ff.ms_cnt < ON_MS |=> !r_ff.en_act)
    else $error("enable before turn-on time");

  // blanking is not cut short by either input
  AST_BLANK_STAYS: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.st == PBS_BLANK && r_ff.ms_cnt < 16'(`PBS_BLANK_MS) |=> r_ff.st == PBS_BLANK)
    else $error("blanking left early");
  // a raised shutdown line at blanking end keeps power and debounces release
  AST_BLANK_PASS: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.st == PBS_BLANK && r_ff.ms_cnt >= 16'(`PBS_BLANK_MS) && !kill_low_raw
    |=> r_ff.st == PBS_REL_DEB && r_ff.en_act)
    else $error("blanking end mishandled");
  // a held button restarts the release debounce
  AST_REL_WAIT: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.st == PBS_REL_DEB && pb_low && !r_ff.kill_low |=> r_ff.st == PBS_REL_DEB && r_ff.ms_cnt == 16'h0000)
    else $error("release debounce not restarted");

  // a high button restarts the request debounce
  AST_NORMAL_RESTART: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.st == PBS_NORMAL && !pb_low && !r_ff.kill_low |=> r_ff.ms_cnt == 16'h0000 && r_ff.pd_req_n)
    else $error("request debounce not restarted");
  // the request only falls out of normal operation
  AST_REQ_FROM_NORMAL: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(r_ff.pd_req_n) |-> $past(r_ff.st) == PBS_NORMAL && r_ff.st == PBS_INT_HOLD)
    else $error("request from wrong state");
  // request held low through the minimum hold
  AST_REQ_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.st == PBS_INT_HOLD && !r_ff.kill_low && r_ff.ms_cnt < 16'(`PBS_INT_MS) |=> !r_ff.pd_req_n)
    else $error("request released early");
  // the request is low only while holding or timing the forced off
  AST_REQ_LOW_STATES: assert property (@(posedge mclk_i) disable iff (rst_i)
    !r_ff.pd_req_n |-> r_ff.st inside {PBS_INT_HOLD, PBS_PD_TIMER})
    else $error("request low in wrong state");
  // a button still low after the hold starts the forced-off timer
  AST_PD_START: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.st == PBS_INT_HOLD && !r_ff.kill_low && r_ff.ms_cnt >= 16'(`PBS_INT_MS) && pb_low
    |=> r_ff.st == PBS_PD_TIMER && !r_ff.pd_req_n)
    else $error("forced-off timer not started");
  // early release keeps the supply and raises the request
  AST_EARLY_RELEASE: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.st == PBS_PD_TIMER && !r_ff.kill_low && !pb_low |=> r_ff.st == PBS_NORMAL && r_ff.en_act && r_ff.pd_req_n)
    else $error("early release mishandled");
  // supply stays on until all cycles are counted
  AST_PD_HOLDS_EN: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.st == PBS_PD_TIMER && !r_ff.kill_low && pb_low && r_ff.pd_cyc < 5'(`PBS_PD_CYCLES) |=> r_ff.en_act)
    else $error("supply dropped before forced-off time");
  // cycle counter never passes its end value
  AST_PD_CYC_RANGE: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.pd_cyc <= 5'(`PBS_PD_CYCLES))
    else $error("forced-off cycle count overrun");

  // lockout keeps everything released
  AST_LOCK_OFF: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.st == PBS_LOCKOUT |-> !r_ff.en_act && r_ff.pd_req_n)
    else $error("outputs active in lockout");
  // lockout lasts its full time
  AST_LOCK_TIME: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.st == PBS_LOCKOUT && r_ff.ms_cnt < 16'(`PBS_LOCK_MS) |=> r_ff.st == PBS_LOCKOUT)
    else $error("lockout too short");

  // the shutdown filter only qualifies after its full count
  AST_KILL_FILTER: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(r_ff.kill_low) |-> $past(r_ff.kill_cnt) == KILL_LAST)
    else $error("shutdown qualified too soon");
  // a high shutdown line clears the filter at once
  AST_KILL_CLEAR: assert property (@(posedge mclk_i) disable iff (rst_i)
    !kill_low_raw |=> !r_ff.kill_low)
    else $error("shutdown filter not cleared");
  // the millisecond tick comes with a prescaler wrap
  AST_TICK_WRAP: assert property (@(posedge mclk_i) disable iff (rst_i)
    r_ff.tick |-> r_ff.tick_cnt == 17'h00000)
    else $error("tick without prescaler wrap");

  // scenario covers
  COV_FORCED_OFF: cover property (@(posedge mclk_i) disable iff (rst_i)
    $past(r_ff.st) == PBS_PD_TIMER && r_ff.st == PBS_IDLE);
  COV_POWER_ON: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(r_ff.en_act));
  COV_ABORT: cover property (@(posedge mclk_i) disable iff (rst_i)
    $past(r_ff.st) == PBS_BLANK && r_ff.st == PBS_IDLE);
  COV_REQ: cover property (@(posedge mclk_i) disable iff (rst_i) $fell(r_ff.pd_req_n));
  COV_LOCK: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(r_ff.st == PBS_LOCKOUT));

endmodule : pbs_sequencer
`default_nettype wire

//--- test/pbs_host_model.sv
// host processor model: raises the shutdown line after power-up, optionally drops it on a request
`timescale 1ns/1ps
`default_nettype none

module pbs_host_model #(
  parameter logic EN_ACTIVE_HIGH = 1'b1
) (
  // clock
  input wire logic mclk_i,
  // from the sequencer
  input wire logic supply_en_i,
  input wire logic pd_req_n_i,
  // scenario control: 0 never raise, 1 raise, 2 raise and obey requests
  input wire logic [1:0] mode_i,
  input wire logic [15:0] raise_dly_i,
  // shutdown command
  output logic kill_n_o
);
  logic powered;
  logic [15:0] up_cnt = 16'h0000;
  logic [7:0] hk_cnt = 8'h00;

  // =====================================================================
  // processor behaviour
  assign powered = (supply_en_i == EN_ACTIVE_HIGH);
  initial kill_n_o = 1'b0;

  // unpowered host holds the line low; powered host raises it after its boot time unless mode is 0
  always @(posedge mclk_i) begin
    if (!powered) begin
      kill_n_o <= #1 1'b0;
      up_cnt <= 16'h0000;
      hk_cnt <= 8'h00;
    end else begin
      up_cnt <= up_cnt + 16'h0001;
      if (mode_i != 2'd0 && up_cnt == raise_dly_i) kill_n_o <= #1 1'b1;
      if (mode_i == 2'd2 && !pd_req_n_i) hk_cnt <= hk_cnt + 8'h01;
      if (hk_cnt == 8'h1e) kill_n_o <= #1 1'b0;
    end
  end
endmodule : pbs_host_model

`default_nettype wire

//--- test/tb_pushbutton_power_sequencer.sv
// testbench for the pushbutton power sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_pushbutton_power_sequencer;
  localparam logic ENH = 1'b1;
  localparam int TK = 10;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic button_in_n_i = 1'b1;
  logic kill_n;
  logic supply_en_o;
  logic pd_req_n_o;
  logic [1:0] host_mode = 2'd0;
  logic [15:0] raise_dly = 16'h0064;
  logic [31:0] seed = 32'h87a5280b;
  logic [1:0] exp_q[$];
  logic [1:0] last_seen = {~ENH, 1'b1};
  int mismatches = 0;
  int comparisons = 0;

  // =====================================================================
  // clock, design and host
  always #4 mclk_i = ~mclk_i;

  pbs_sequencer #(.EN_ACTIVE_HIGH(ENH), .TURN_ON_EXTRA_DELAY(16'h0004), .FORCED_OFF_EXTRA_DELAY(16'h0010),
    .TICK_CYC(TK), .KILL_PW_CYC(4)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .button_in_n_i(button_in_n_i),
    .kill_n_i(kill_n), .supply_en_o(supply_en_o), .pd_req_n_o(pd_req_n_o));

  pbs_host_model #(.EN_ACTIVE_HIGH(ENH)) host (.mclk_i(mclk_i), .supply_en_i(supply_en_o),
    .pd_req_n_i(pd_req_n_o), .mode_i(host_mode), .raise_dly_i(raise_dly), .kill_n_o(kill_n));

  // =====================================================================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic check(input logic [1:0] seen, input logic [1:0] expv);
    comparisons++;
    if (seen !== expv) begin
      mismatches++;
      $display("ERROR %0t: saw %b expected %b", $time, seen, expv);
    end
  endtask : check

  task automatic note(input logic on, input logic req_n);
    exp_q.push_back({on ? ENH : ~ENH, req_n});
  endtask : note

  task automatic wait_ms(input int n);
    repeat (n * TK) @(posedge mclk_i);
    #1;
  endtask : wait_ms

  task automatic pend(input int n);
    check(2'(exp_q.size()), 2'(n));
  endtask : pend

  // wait a bounded time for every noted change to appear
  task automatic drain(input int n);
    for (int i = 0; i < n * TK && exp_q.size() != 0; i++) @(posedge mclk_i);
    #1;
    pend(0);
  endtask : drain

  task automatic press(input int n);
    button_in_n_i = 1'b0;
    wait_ms(n);
    button_in_n_i = 1'b1;
  endtask : press

  task automatic power_on();
    button_in_n_i = 1'b0;
    note(1'b1, 1'b1);
    drain(45);
    button_in_n_i = 1'b1;
    wait_ms(560);
  endtask : power_on

  // =====================================================================
  // output watcher: every change must match the oldest note
  always @(negedge mclk_i) begin
    if (!rst_i && {supply_en_o, pd_req_n_o} !== last_seen) begin
      check({supply_en_o, pd_req_n_o}, exp_q.size() != 0 ? exp_q.pop_front() : last_seen);
      last_seen <= {supply_en_o, pd_req_n_o};
    end
  end

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  initial begin
    repeat (80000) @(posedge mclk_i);
    mismatches++;
    final_report();
  end

  // =====================================================================
  // scenarios
  initial begin
    repeat (8) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    check({supply_en_o, pd_req_n_o}, {~ENH, 1'b1});
    press(2 + int'(xs() % 20));
    wait_ms(40);
    button_in_n_i = 1'b0;
    note(1'b1, 1'b1);
    wait_ms(33);
    pend(1);
    drain(8);
    note(1'b0, 1'b1);
    wait_ms(505);
    pend(1);
    drain(20);
    button_in_n_i = 1'b1;
    wait_ms(40);
    host_mode = 2'd1;
    raise_dly = 16'(TK * (10 + int'(xs() % 400)));
    power_on();
    press(20);
    wait_ms(10);
    note(1'b1, 1'b0);
    note(1'b1, 1'b1);
    press(40);
    wait_ms(15);
    pend(1);
    drain(20);
    button_in_n_i = 1'b0;
    note(1'b1, 1'b0);
    note(1'b0, 1'b1);
    wait_ms(76);
    pend(1);
    drain(10);
    button_in_n_i = 1'b1;
    wait_ms(10);
    host_mode = 2'd2;
    power_on();
    note(1'b1, 1'b0);
    note(1'b0, 1'b1);
    press(45);
    drain(10);
    press(40);
    wait_ms(250);
    power_on();
    final_report();
  end
endmodule : tb_pushbutton_power_sequencer

`default_nettype wire
